// [core/dalg_gate.sv]
// Debug access lock gate top
`include "dalg_defines.svh"
`default_nettype none
module dalg_gate
    import dalg_pkg::*;
(
    // Clock and reset
    input  wire logic                clk_i,
    input  wire logic                nrst_i,
    // Access request from CPU or debug port
    input  wire logic                req_i,
    input  wire logic                dbg_i,
    input  wire logic                wr_i,
    input  wire logic                fuse_cmd_i,
    input  wire dalg_pkg::dalg_sec_t sec_i,
    input  wire logic [31:0]         wdata_i,
    input  wire logic [31:0]         mem_rdata_i,
    // Access to memory bus
    output logic                     mem_req_o,
    output logic                     mem_wr_o,
    output dalg_pkg::dalg_sec_t      mem_sec_o,
    output logic [31:0]              mem_wdata_o,
    output logic                     rvalid_o,
    output logic [31:0]              rdata_o,
    // Chip erase command and outputs
    input  wire logic                erase_i,
    output logic                     erase_busy_o,
    output logic                     erase_eeprom_o,
    output logic                     locked_o,
    // Register port
    input  wire logic [7:0]          addr_i,
    input  wire logic [31:0]         reg_wdata_i,
    input  wire logic                reg_wr_i,
    input  wire logic                reg_rd_i,
    output logic [31:0]              reg_rdata_o
);
    ////////////////////////////////////////////////////////////////////////
    logic [31:0] key_reg, key_next;
    logic        keep_ee_reg, keep_ee_next;
    logic [7:0]  ecnt_reg, ecnt_next;
    logic        ee_reg, ee_next;
    logic        busy_reg, busy_next;
    logic        mreq_reg, mwr_reg, rv_reg, rvpend_reg, rok_reg;
    logic [31:0] mwd_reg, rd_reg, rrd_reg, rrd_next;
    dalg_sec_t   msec_reg;
    logic        allow, locked, key_wr;

    // Lock state from key on every access
    assign locked = (key_reg != `DALG_UNLOCK_KEY);

    dalg_perm u_perm (
        .dbg_i      (dbg_i),
        .wr_i       (wr_i),
        .fuse_cmd_i (fuse_cmd_i),
        .sec_i      (sec_i),
        .locked_i   (locked),
        .allow_o    (allow)
    );

    // Debug write to lock word stores key
    assign key_wr = req_i && wr_i && dbg_i && allow && sec_i == DALG_SEC_LOCK;

    ////////////////////////////////////////////////////////////////////////
    // Key, config and erase next state
    always_comb begin
        key_next     = key_reg;
        keep_ee_next = keep_ee_reg;
        ecnt_next    = ecnt_reg;
        ee_next      = ee_reg;
        if (key_wr && ecnt_reg == 8'h00) begin
            key_next = wdata_i;
        end
        if (reg_wr_i && addr_i == `DALG_OFF_CFG) begin
            keep_ee_next = reg_wdata_i[0];
        end
        if (ecnt_reg != 8'h00) begin
            ecnt_next = ecnt_reg - 8'h01;
            if (ecnt_reg == 8'h01) begin
                key_next = `DALG_UNLOCK_KEY;
            end
        end else if (erase_i || (reg_wr_i && addr_i == `DALG_OFF_ERASE)) begin
            ecnt_next = `DALG_ERASE_CYCLES;
            ee_next   = locked || !keep_ee_reg;
        end
        // Busy flag kept in a flop, in step with the counter
        busy_next = (ecnt_next != 8'h00);
    end

    // Register key, config and erase state
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            key_reg     <= `DALG_UNLOCK_KEY;
            keep_ee_reg <= 1'b0;
            ecnt_reg    <= 8'h00;
            ee_reg      <= 1'b0;
            busy_reg    <= 1'b0;
        end else begin
            key_reg     <= key_next;
            keep_ee_reg <= keep_ee_next;
            ecnt_reg    <= ecnt_next;
            ee_reg      <= ee_next;
            busy_reg    <= busy_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Forward allowed accesses, mask refused ones and writes during erase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mreq_reg   <= 1'b0;
            mwr_reg    <= 1'b0;
            msec_reg   <= DALG_SEC_FLASH;
            mwd_reg    <= 32'h00000000;
            rvpend_reg <= 1'b0;
            rok_reg    <= 1'b0;
            rv_reg     <= 1'b0;
            rd_reg     <= 32'h00000000;
        end else begin
            mreq_reg   <= req_i && allow && !(wr_i && ecnt_reg != 8'h00);
            mwr_reg    <= wr_i;
            msec_reg   <= sec_i;
            mwd_reg    <= wdata_i;
            rvpend_reg <= req_i && !wr_i;
            rok_reg    <= allow;
            rv_reg     <= rvpend_reg;
            // Blocked reads still complete, data invalid
            rd_reg     <= rok_reg ? mem_rdata_i : `DALG_FAKE_DATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read mux, key read-only
    always_comb begin
        rrd_next = rrd_reg;
        if (reg_rd_i) begin
            unique case (addr_i)
                `DALG_OFF_KEY:    rrd_next = key_reg;
                `DALG_OFF_STATUS: rrd_next = {30'h0, ecnt_reg != 8'h00, locked};
                `DALG_OFF_CFG:    rrd_next = {31'h0, keep_ee_reg};
                default:          rrd_next = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rrd_reg <= 32'h00000000;
        end else begin
            rrd_reg <= rrd_next;
        end
    end

    // Status flops for outputs
    logic lk_reg;
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lk_reg <= 1'b0;
        end else begin
            lk_reg <= locked;
        end
    end

    assign mem_req_o      = mreq_reg;
    assign mem_wr_o       = mwr_reg;
    assign mem_sec_o      = msec_reg;
    assign mem_wdata_o    = mwd_reg;
    assign rvalid_o       = rv_reg;
    assign rdata_o        = rd_reg;
    assign erase_busy_o   = busy_reg;
    assign erase_eeprom_o = ee_reg;
    assign locked_o       = lk_reg;
    assign reg_rdata_o    = rrd_reg;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the gate and the key
    a_cpu_unaffected: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && !dbg_i && sec_i == DALG_SEC_FLASH |=> mem_req_o) else $error("cpu blocked");
    a_locked_read: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && dbg_i && !wr_i && locked |-> ##2 rdata_o == `DALG_FAKE_DATA) else $error("data leak");
    a_read_completes: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && !wr_i |-> ##2 rvalid_o) else $error("read not completed");
    a_locked_block: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && dbg_i && locked && !(wr_i && fuse_cmd_i && sec_i == DALG_SEC_USER_ROW_A)
        |=> !mem_req_o) else $error("locked access passed");
    a_user_row_a_wr: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && dbg_i && wr_i && fuse_cmd_i && sec_i == DALG_SEC_USER_ROW_A && ecnt_reg == 8'h00
        |=> mem_req_o && mem_wr_o) else $error("user row write lost");
    a_key_unlock: assert property (@(posedge clk_i) disable iff (!nrst_i)
        $rose(locked_o) |-> $past(key_reg) != `DALG_UNLOCK_KEY) else $error("bad lock");
    a_key_readonly: assert property (@(posedge clk_i) disable iff (!nrst_i)
        reg_wr_i && addr_i == `DALG_OFF_KEY && !req_i && ecnt_reg == 8'h00 |=> $stable(key_reg))
        else $error("key written from register port");
    a_cpu_no_key: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && !dbg_i && wr_i && sec_i == DALG_SEC_LOCK && ecnt_reg == 8'h00 |=> $stable(key_reg))
        else $error("cpu wrote key");
    a_erase_unlocks: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ecnt_reg == 8'h01 |=> !locked) else $error("erase no unlock");
    a_erase_eeprom: assert property (@(posedge clk_i) disable iff (!nrst_i)
        ecnt_reg == 8'h00 && erase_i && locked |=> erase_eeprom_o) else $error("eeprom kept");
    a_signature_row_wr: assert property (@(posedge clk_i) disable iff (!nrst_i)
        req_i && wr_i && sec_i == DALG_SEC_SIGNATURE_ROW |=> !mem_req_o) else $error("signature_row write");
    // Main scenarios reached
    c_lock: cover property (@(posedge clk_i) disable iff (!nrst_i) $rose(locked_o));
    c_erase: cover property (@(posedge clk_i) disable iff (!nrst_i) $fell(erase_busy_o));
    c_urow: cover property (@(posedge clk_i) disable iff (!nrst_i) locked && mem_req_o && mem_wr_o);
    c_blocked_read: cover property (@(posedge clk_i) disable iff (!nrst_i) req_i && dbg_i && !wr_i && locked);
endmodule : dalg_gate
`default_nettype wire

// [core/dalg_defines.svh]
// Constants for the debug access lock gate
`ifndef DALG_DEFINES_SVH
`define DALG_DEFINES_SVH
`define DALG_UNLOCK_KEY    32'h5cc5c55c
`define DALG_OFF_KEY       8'h00
`define DALG_OFF_STATUS    8'h04
`define DALG_OFF_CFG       8'h08
`define DALG_OFF_ERASE     8'h0c
`define DALG_FAKE_DATA     32'h00000000
`define DALG_ERASE_CYCLES  8'h10
`endif

// [core/dalg_pkg.sv]
// Types for the debug access lock gate
`default_nettype none
package dalg_pkg;
    // Memory sections seen by both masters
    typedef enum logic [2:0] {
        DALG_SEC_FLASH,
        DALG_SEC_SRAM,
        DALG_SEC_EEPROM,
        DALG_SEC_SIGNATURE_ROW,
        DALG_SEC_USER_ROW_A,
        DALG_SEC_FUSE,
        DALG_SEC_LOCK,
        DALG_SEC_REGS
    } dalg_sec_t;
endpackage : dalg_pkg
`default_nettype wire

// [core/dalg_perm.sv]
// Access permission decode for one access
`default_nettype none
module dalg_perm
    import dalg_pkg::*;
(
    // Access request
    input  wire logic             dbg_i,
    input  wire logic             wr_i,
    input  wire logic             fuse_cmd_i,
    input  wire dalg_pkg::dalg_sec_t sec_i,
    input  wire logic             locked_i,
    // Verdict
    output logic                  allow_o
);
    // Permission table per master and lock state
    always_comb begin
        allow_o = 1'b1;
        if (!dbg_i) begin
            // CPU never writes signature row, fuses, lock word
            if (wr_i && (sec_i == DALG_SEC_SIGNATURE_ROW || sec_i == DALG_SEC_FUSE || sec_i == DALG_SEC_LOCK)) begin
                allow_o = 1'b0;
            end
        end else if (!locked_i) begin
            if (wr_i && sec_i == DALG_SEC_SIGNATURE_ROW) begin
                allow_o = 1'b0;
            end
        end else begin
            // Locked: only user row writes via fuse-write command
            allow_o = wr_i && fuse_cmd_i && (sec_i == DALG_SEC_USER_ROW_A);
        end
    end
endmodule : dalg_perm
`default_nettype wire

// [test/dalg_mem_model.sv]
// Memory model standing behind the lock gate
`default_nettype none
module dalg_mem_model
    import dalg_pkg::*;
(
    // Forwarded access
    input  wire logic                clk_i,
    input  wire logic                mem_req_i,
    input  wire logic                mem_wr_i,
    input  wire dalg_pkg::dalg_sec_t mem_sec_i,
    input  wire logic [31:0]         mem_wdata_i,
    // Read data, in the cycle of the forwarded read
    output logic [31:0]              rdata_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [8];
    logic [31:0] idle_q;
    // Non-zero start contents, so a leak differs from the masked value
    initial begin
        idle_q = 32'ha5a5a5a5;
        for (int i = 0; i < 8; i++) mem[i] = 32'hc0de0000 + i;
    end
    // Stores forwarded writes only; idle pattern toggles each cycle
    always @(posedge clk_i) begin
        if (mem_req_i && mem_wr_i) mem[mem_sec_i] <= mem_wdata_i;
        idle_q <= ~idle_q;
    end
    // Contents while a read is forwarded, idle pattern otherwise
    assign rdata_o = (mem_req_i && !mem_wr_i) ? mem[mem_sec_i] : idle_q;
endmodule : dalg_mem_model
`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench for the lock gate
`include "dalg_defines.svh"
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import dalg_pkg::*;
    logic clk_i = 0, nrst_i = 0, req_i = 0, dbg_i = 0, wr_i = 0, fuse_cmd_i = 0, erase_i = 0;
    logic reg_wr_i = 0, reg_rd_i = 0, mem_req_o, mem_wr_o, rvalid_o, erase_busy_o, erase_eeprom_o, locked_o;
    dalg_sec_t sec_i = DALG_SEC_FLASH, mem_sec_o;
    logic [31:0] wdata_i = 0, mem_rdata_i, mem_wdata_o, rdata_o, reg_wdata_i = 0, reg_rdata_o;
    logic [7:0]  addr_i = 0;
    int errors = 0, comparisons = 0, cyc = 0, seed = 73, n;
    logic lk = 0;
    logic [31:0] shadow [8];
    always #10 clk_i = ~clk_i;
    dalg_gate DUT (.clk_i(clk_i), .nrst_i(nrst_i), .req_i(req_i), .dbg_i(dbg_i), .wr_i(wr_i),
        .fuse_cmd_i(fuse_cmd_i), .sec_i(sec_i), .wdata_i(wdata_i), .mem_rdata_i(mem_rdata_i),
        .mem_req_o(mem_req_o), .mem_wr_o(mem_wr_o), .mem_sec_o(mem_sec_o), .mem_wdata_o(mem_wdata_o),
        .rvalid_o(rvalid_o), .rdata_o(rdata_o), .erase_i(erase_i), .erase_busy_o(erase_busy_o),
        .erase_eeprom_o(erase_eeprom_o), .locked_o(locked_o), .addr_i(addr_i), .reg_wdata_i(reg_wdata_i),
        .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o));
    dalg_mem_model MEM (.clk_i(clk_i), .mem_req_i(mem_req_o), .mem_wr_i(mem_wr_o), .mem_sec_i(mem_sec_o),
        .mem_wdata_i(mem_wdata_o), .rdata_o(mem_rdata_i));
    ////////////////////////////////////////////////////////////////////////////////
    // Verdict and comparison
    task automatic end_sim();
        if (errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errors++;
            $display("unexpected %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    // Expected verdict of the gate
    function automatic logic ok_f(logic d, logic w, logic f, dalg_sec_t s, logic l);
        if (!d) return !(w && (s == DALG_SEC_SIGNATURE_ROW || s == DALG_SEC_FUSE || s == DALG_SEC_LOCK));
        if (l) return w && f && s == DALG_SEC_USER_ROW_A;
        return !(w && s == DALG_SEC_SIGNATURE_ROW);
    endfunction : ok_f
    ////////////////////////////////////////////////////////////////////////////////
    // Bus tasks
    task automatic acc(input logic d, w, f, input dalg_sec_t s, input logic [31:0] v);
        logic a;
        a = ok_f(d, w, f, s, lk);
        @(posedge clk_i);
        req_i      <= 1'b1;
        dbg_i      <= d;
        wr_i       <= w;
        fuse_cmd_i <= f;
        sec_i      <= s;
        wdata_i    <= v;
        @(posedge clk_i);
        req_i <= 1'b0;
        #1 chk("mem_req", a, mem_req_o);
        if (a) chk("mem_wr", {s, w}, {mem_sec_o, mem_wr_o});
        if (a && w) chk("mem_wdata", v, mem_wdata_o);
        if (a && w) shadow[s] = v;
        if (a && d && w && s == DALG_SEC_LOCK) lk = (v !== `DALG_UNLOCK_KEY);
        if (!w) begin
            @(posedge clk_i);
            #1 chk("rvalid", 1, rvalid_o);
            if (!a) chk("rdata", `DALG_FAKE_DATA, rdata_o);
            else chk("rdata", shadow[s], rdata_o);
        end
    endtask : acc
    task automatic rw(input logic [7:0] ad, input logic [31:0] v);
        @(posedge clk_i);
        {reg_wr_i, addr_i, reg_wdata_i} <= {1'b1, ad, v};
        @(posedge clk_i);
        reg_wr_i <= 0;
    endtask : rw
    task automatic rr(input logic [7:0] ad, input logic [31:0] e);
        @(posedge clk_i);
        {reg_rd_i, addr_i} <= {1'b1, ad};
        @(posedge clk_i);
        reg_rd_i <= 0;
        #1 chk("reg_rdata", e, reg_rdata_o);
    endtask : rr
    // Called just after the edge that took the erase
    task automatic wait_erase();
        chk("erase_busy", 1, erase_busy_o);
        for (n = 0; n < 100 && erase_busy_o === 1'b1; n++) @(posedge clk_i) #1;
        chk("erase_len", `DALG_ERASE_CYCLES, n);
        @(posedge clk_i) #1;
        chk("locked", 0, locked_o);
        lk = 0;
    endtask : wait_erase
    ////////////////////////////////////////////////////////////////////////////////
    // Hang guard
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 20000) begin
            errors++;
            end_sim();
        end
    end
    // Main sequence
    initial begin
        // Same start contents as the memory model
        for (int i = 0; i < 8; i++) shadow[i] = 32'hc0de0000 + i;
        repeat (16) @(posedge clk_i);
        nrst_i <= 1;
        #1 chk("locked", 0, locked_o);
        rr(`DALG_OFF_KEY, `DALG_UNLOCK_KEY);
        rw(`DALG_OFF_KEY, 32'h12345678);
        rr(`DALG_OFF_KEY, `DALG_UNLOCK_KEY);
        rr(8'h10, 32'h0);
        for (int p = 0; p < 2; p++) begin
            if (p == 1) begin
                acc(1, 1, 0, DALG_SEC_LOCK, 32'h5cc5c55d);
                repeat (2) @(posedge clk_i);
                #1 chk("locked", 1, locked_o);
                rr(`DALG_OFF_KEY, 32'h5cc5c55d);
                rr(`DALG_OFF_STATUS, 32'h1);
            end
            for (int i = 0; i < 64; i++)
                acc(i[0], i[1], i[2], dalg_sec_t'(i[5:3]), p ? $random(seed) : `DALG_UNLOCK_KEY);
        end
        rw(`DALG_OFF_CFG, 32'h1);
        rr(`DALG_OFF_CFG, 32'h1);
        @(posedge clk_i);
        erase_i <= 1;
        @(posedge clk_i);
        erase_i <= 0;
        #1 chk("erase_eeprom", 1, erase_eeprom_o);
        wait_erase();
        rr(`DALG_OFF_STATUS, 32'h0);
        rr(`DALG_OFF_KEY, `DALG_UNLOCK_KEY);
        rw(`DALG_OFF_ERASE, 32'h1);
        #1 chk("erase_eeprom", 0, erase_eeprom_o);
        wait_erase();
        repeat (150) acc($random(seed), $random(seed), $random(seed), dalg_sec_t'($random(seed) & 7),
            ($random(seed) & 1) ? `DALG_UNLOCK_KEY : $random(seed));
        end_sim();
    end
endmodule : tb_top
`default_nettype wire
